/* File: ofl_top.v */
// Overview of operation
// - Selections 0..31: bit0 no fast limit, bits1-3 no accel/const/decel stall prevention, bit4 stop on warning.
// - Selection 100 limits fully when driving and not at all when regenerating; 101 drops fast limit when driving.
// - With stop-on-warning chosen, the drive stops with the stall stop fault when the warning would assert.
// - In a phase with stall prevention off, neither the overload warning nor the drop trip fault is raised.
// - Fast current limiting alone never raises the overload warning.
// - Stall prevention holding output at or below 1 Hz for 3 s raises the trip fault and trips.
// - The maximum frequency accepts 0..120 Hz, resets to 120 Hz, and is the output ceiling.
// - A command above the maximum is held at the maximum.
// - The high-speed maximum accepts 120..400 Hz, resets to 120 Hz, and is the ceiling for work above 120 Hz.
// - Writing either maximum copies the value into the other.
// - The minimum frequency accepts 0..120 Hz, resets to 0 Hz, and is the output floor.
// - A command below the minimum is held at the minimum (or at a lower maximum, which wins), except while stall prevention is active.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "ofl_consts.vh"

module ofl_top #(
  parameter FW       = `OFL_FREQ_W,
  parameter TRIP_CYC = `OFL_TRIP_CYC
) (
  input  wire                   sys_clk,
  input  wire                   rstn,
  input  wire [`OFL_ADDR_W-1:0] addr,
  input  wire [`OFL_DATA_W-1:0] wr_data,
  input  wire                   wr_en,
  input  wire                   rd_en,
  output wire [`OFL_DATA_W-1:0] rd_data,
  input  wire [FW-1:0]          freq_cmd,
  input  wire                   freq_upd,
  input  wire                   phase_accel,
  input  wire                   phase_const,
  input  wire                   phase_decel,
  input  wire                   regen,
  input  wire                   stall_cond,
  input  wire                   fast_cond,
  output wire [FW-1:0]          out_freq,
  output wire                   overload_warning,
  output wire                   stall_stop_fault,
  output wire                   stall_trip_fault,
  output wire                   run_ok,
  output wire                   stall_active,
  output wire                   fast_limit_active,
  output wire                   irq
);

  // ************************************************************
  // constants and functions
  // ************************************************************
  localparam [2:0] ST_RUN  = 3'h1;
  localparam [2:0] ST_STOP = 3'h2;
  localparam [2:0] ST_TRIP = 3'h4;
  localparam [31:0] TRIP_LAST = TRIP_CYC - 1;

  // saturate a written value into [lo, hi]
  function [FW-1:0] ofl_sat;
    input [`OFL_DATA_W-1:0] v;
    input [FW-1:0]          lo;
    input [FW-1:0]          hi;
    begin
      if (v > {16'h0000, hi})
        ofl_sat = hi;
      else if (v < {16'h0000, lo})
        ofl_sat = lo;
      else
        ofl_sat = v[FW-1:0];
    end
  endfunction

  // selection to {stop_warn, no_dec, no_const, no_acc, no_fast}
  function [4:0] ofl_decode;
    input [`OFL_SEL_W-1:0] sel;
    input                  rg;
    begin
      if (sel <= `OFL_SEL_BITMAX)
        ofl_decode = sel[4:0];
      else if (rg)
        ofl_decode = 5'h0F;
      else if (sel == `OFL_SEL_DRV_NOFR)
        ofl_decode = 5'h01;
      else
        ofl_decode = 5'h00;
    end
  endfunction

  // ************************************************************
  // registers
  // ************************************************************
  reg [FW-1:0]             max_ff;
  reg [FW-1:0]             min_ff;
  reg [`OFL_SEL_W-1:0]     sel_ff;
  reg [`OFL_INT_W-1:0]     int_stat_ff;
  reg [`OFL_INT_W-1:0]     int_mask_ff;
  reg [`OFL_DATA_W-1:0]    rd_data_ff;
  reg [2:0]                state_ff;
  reg [2:0]                nxt_state;
  reg [31:0]               trip_cnt_ff;
  reg                      warn_ff;
  reg                      stall_ff;
  reg                      fast_ff;
  reg                      irq_ff;
  reg [`OFL_DATA_W-1:0]    nxt_rd;
  wire [4:0]               dec;
  wire                     phase_on;
  wire                     stall_now;
  wire                     stop_req;
  wire                     trip_req;
  wire                     fault_clr;
  wire [`OFL_INT_W-1:0]    int_evt;
  wire [FW-1:0]            clamp_out;
  wire                     clamp_hi;
  wire                     clamp_lo;
  wire                     running;

  // ************************************************************
  // limit and selection registers
  // ************************************************************
  // both maxima share one storage so each write shows up in the other
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      max_ff <= `OFL_MAX_RST;
      min_ff <= `OFL_MIN_RST;
      sel_ff <= `OFL_SEL_RST;
    end else if (wr_en) begin
      case (addr)
        `OFL_REG_MAX: begin
          max_ff <= ofl_sat(wr_data, `OFL_F_ZERO, `OFL_F_120HZ);
        end
        `OFL_REG_HSMAX: begin
          max_ff <= ofl_sat(wr_data, `OFL_F_120HZ, `OFL_F_400HZ);
        end
        `OFL_REG_MIN: begin
          min_ff <= ofl_sat(wr_data, `OFL_F_ZERO, `OFL_F_120HZ);
        end
        `OFL_REG_STALL: begin
          // unsupported codes are ignored, the old selection stays
          if ((wr_data <= {24'h000000, `OFL_SEL_BITMAX}) ||
              (wr_data == {24'h000000, `OFL_SEL_DRV_ALL}) ||
              (wr_data == {24'h000000, `OFL_SEL_DRV_NOFR}))
            sel_ff <= wr_data[`OFL_SEL_W-1:0];
        end
        default: begin
          sel_ff <= sel_ff;
        end
      endcase
    end
  end

  assign fault_clr = wr_en && (addr == `OFL_REG_CTRL) && wr_data[`OFL_CTRL_CLR];

  // ************************************************************
  // stall supervision
  // ************************************************************
  assign dec       = ofl_decode(sel_ff, regen);
  assign running   = (state_ff == ST_RUN);
  assign phase_on  = (phase_accel && !dec[`OFL_D_NOACC]) ||
                     (phase_const && !dec[`OFL_D_NOCONST]) ||
                     (phase_decel && !dec[`OFL_D_NODEC]);
  // stall only counts in a phase where it is enabled
  assign stall_now = running && stall_cond && phase_on;
  assign stop_req  = stall_now && dec[`OFL_D_STOPOL];
  assign trip_req  = stall_now && (clamp_out <= `OFL_F_1HZ) &&
                     (trip_cnt_ff == TRIP_LAST);

  // low-frequency dwell timer, restarts whenever the condition breaks
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      trip_cnt_ff <= 32'h00000000;
    else if (!stall_now || (clamp_out > `OFL_F_1HZ))
      trip_cnt_ff <= 32'h00000000;
    else if (trip_cnt_ff != TRIP_LAST)
      trip_cnt_ff <= trip_cnt_ff + 32'h00000001;
  end

  // run / stopped-by-stall / tripped
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (stop_req)
          nxt_state = ST_STOP;
        else if (trip_req)
          nxt_state = ST_TRIP;
      end
      ST_STOP: begin
        if (fault_clr)
          nxt_state = ST_RUN;
      end
      ST_TRIP: begin
        if (fault_clr)
          nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      state_ff <= ST_RUN;
    else
      state_ff <= nxt_state;
  end

  // warning and activity flags; fast limit alone raises only fast_ff, no warning or stall flag
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      warn_ff  <= 1'b0;
      stall_ff <= 1'b0;
      fast_ff  <= 1'b0;
    end else begin
      warn_ff  <= stall_now && !dec[`OFL_D_STOPOL];
      stall_ff <= stall_now && !dec[`OFL_D_STOPOL];
      fast_ff  <= running && fast_cond && !dec[`OFL_D_NOFAST];
    end
  end

  // ************************************************************
  // output clamp
  // ************************************************************
  // stall may pull the output under the floor, so skip it then
  ofl_clamp #(
    .W (FW)
  ) u_clamp (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .upd       (freq_upd),
    .hold_zero (!running),
    .skip_min  (stall_ff),
    .cmd       (freq_cmd),
    .max_lim   (max_ff),
    .min_lim   (min_ff),
    .out_ff    (clamp_out),
    .hi_ff     (clamp_hi),
    .lo_ff     (clamp_lo)
  );

  // ************************************************************
  // interrupts
  // ************************************************************
  assign int_evt = {trip_req, stop_req, stall_now && !dec[`OFL_D_STOPOL] && !warn_ff};

  // sticky events, write one to clear, a new event beats the clear
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      int_stat_ff <= {`OFL_INT_W{1'b0}};
      int_mask_ff <= {`OFL_INT_W{1'b0}};
      irq_ff      <= 1'b0;
    end else begin
      if (wr_en && (addr == `OFL_REG_INT_STAT))
        int_stat_ff <= (int_stat_ff & ~wr_data[`OFL_INT_W-1:0]) | int_evt;
      else
        int_stat_ff <= int_stat_ff | int_evt;
      if (wr_en && (addr == `OFL_REG_INT_MASK))
        int_mask_ff <= wr_data[`OFL_INT_W-1:0];
      irq_ff <= |(int_stat_ff & int_mask_ff);
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  always @* begin
    nxt_rd = {`OFL_DATA_W{1'b0}};
    case (addr)
      `OFL_REG_MAX:      nxt_rd[FW-1:0] = max_ff;
      `OFL_REG_HSMAX:    nxt_rd[FW-1:0] = max_ff;
      `OFL_REG_MIN:      nxt_rd[FW-1:0] = min_ff;
      `OFL_REG_STALL:    nxt_rd[`OFL_SEL_W-1:0] = sel_ff;
      `OFL_REG_STATUS: begin
        nxt_rd[`OFL_ST_WARN] = warn_ff;
        nxt_rd[`OFL_ST_STOP] = (state_ff == ST_STOP);
        nxt_rd[`OFL_ST_TRIP] = (state_ff == ST_TRIP);
        nxt_rd[`OFL_ST_RUN]  = running;
        nxt_rd[`OFL_ST_HI]   = clamp_hi;
        nxt_rd[`OFL_ST_LO]   = clamp_lo;
      end
      `OFL_REG_INT_STAT: nxt_rd[`OFL_INT_W-1:0] = int_stat_ff;
      `OFL_REG_INT_MASK: nxt_rd[`OFL_INT_W-1:0] = int_mask_ff;
      default:           nxt_rd = {`OFL_DATA_W{1'b0}};
    endcase
  end

  // data valid only in the cycle after the read strobe
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      rd_data_ff <= {`OFL_DATA_W{1'b0}};
    else if (rd_en)
      rd_data_ff <= nxt_rd;
    else
      rd_data_ff <= {`OFL_DATA_W{1'b0}};
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign rd_data           = rd_data_ff;
  assign out_freq          = clamp_out;
  assign overload_warning  = warn_ff;
  assign stall_stop_fault  = state_ff[1]; // one-hot stop bit, no decode logic on the pin
  assign stall_trip_fault  = state_ff[2]; // one-hot trip bit
  assign run_ok            = state_ff[0]; // one-hot run bit
  assign stall_active      = stall_ff;
  assign fast_limit_active = fast_ff;
  assign irq               = irq_ff;

endmodule

/* File: ofl_consts.vh */
`ifndef OFL_CONSTS_VH
`define OFL_CONSTS_VH

// ************************************************************
// widths
// ************************************************************
`define OFL_FREQ_W        16
`define OFL_ADDR_W        8
`define OFL_DATA_W        32
`define OFL_SEL_W         8

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define OFL_REG_MAX       8'h00
`define OFL_REG_HSMAX     8'h04
`define OFL_REG_MIN       8'h08
`define OFL_REG_STALL     8'h0C
`define OFL_REG_STATUS    8'h10
`define OFL_REG_INT_STAT  8'h14
`define OFL_REG_INT_MASK  8'h18
`define OFL_REG_CTRL      8'h1C

// ************************************************************
// frequency limits, unit 0.01 Hz
// ************************************************************
`define OFL_F_ZERO        16'h0000
`define OFL_F_1HZ         16'h0064
`define OFL_F_120HZ       16'h2EE0
`define OFL_F_400HZ       16'h9C40
`define OFL_MAX_RST       `OFL_F_120HZ
`define OFL_MIN_RST       `OFL_F_ZERO

// ************************************************************
// stall selection codes
// ************************************************************
`define OFL_SEL_RST       8'h00
`define OFL_SEL_BITMAX    8'h1F
`define OFL_SEL_DRV_ALL   8'h64
`define OFL_SEL_DRV_NOFR  8'h65

// decoded stall field positions
`define OFL_D_NOFAST      0
`define OFL_D_NOACC       1
`define OFL_D_NOCONST     2
`define OFL_D_NODEC       3
`define OFL_D_STOPOL      4

// ************************************************************
// status and interrupt bit positions
// ************************************************************
`define OFL_ST_WARN       0
`define OFL_ST_STOP       1
`define OFL_ST_TRIP       2
`define OFL_ST_RUN        3
`define OFL_ST_HI         4
`define OFL_ST_LO         5
`define OFL_INT_W         3
`define OFL_CTRL_CLR      0

// ************************************************************
// timing
// ************************************************************
`define OFL_CLK_KHZ       125000
`define OFL_TRIP_TIME_MS  3000
`define OFL_TRIP_CYC      (`OFL_TRIP_TIME_MS * `OFL_CLK_KHZ)

`endif

/* File: ofl_clamp.v */
`timescale 1ns/100ps
`include "ofl_consts.vh"

// ************************************************************
// registered output frequency clamp
// ************************************************************
module ofl_clamp #(
  parameter W = `OFL_FREQ_W
) (
  input  wire         sys_clk,
  input  wire         rstn,
  input  wire         upd,
  input  wire         hold_zero,
  input  wire         skip_min,
  input  wire [W-1:0] cmd,
  input  wire [W-1:0] max_lim,
  input  wire [W-1:0] min_lim,
  output reg  [W-1:0] out_ff,
  output reg          hi_ff,
  output reg          lo_ff
);

  reg [W-1:0] lo_v;
  reg [W-1:0] nxt_out;
  reg         nxt_hi;
  reg         nxt_lo;

  // lower bound first, upper bound last so max always wins
  always @* begin
    lo_v    = cmd;
    nxt_lo  = 1'b0;
    nxt_hi  = 1'b0;
    if (!skip_min && (cmd < min_lim)) begin
      lo_v   = min_lim;
      nxt_lo = 1'b1;
    end
    nxt_out = lo_v;
    if (lo_v > max_lim) begin
      nxt_out = max_lim;
      nxt_hi  = 1'b1;
      nxt_lo  = 1'b0;
    end
  end

  // new result on each update, limits sampled fresh each time
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      out_ff <= {W{1'b0}};
      hi_ff  <= 1'b0;
      lo_ff  <= 1'b0;
    end else if (hold_zero) begin
      out_ff <= {W{1'b0}};
      hi_ff  <= 1'b0;
      lo_ff  <= 1'b0;
    end else if (upd) begin
      out_ff <= nxt_out;
      hi_ff  <= nxt_hi;
      lo_ff  <= nxt_lo;
    end
  end

endmodule

/* File: ofl_chk_sva.sv */
`timescale 1ns/100ps
// ************************************************************
// port checker for the frequency limiter
// ************************************************************
module ofl_chk (
  input wire        sys_clk,
  input wire        rstn,
  input wire        rd_en,
  input wire [31:0] rd_data,
  input wire        stall_cond,
  input wire        fast_cond,
  input wire        phase_accel,
  input wire        phase_const,
  input wire        phase_decel,
  input wire [15:0] out_freq,
  input wire        overload_warning,
  input wire        stall_stop_fault,
  input wire        stall_trip_fault,
  input wire        run_ok,
  input wire        fast_limit_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // warning and fault causes
  chk_fast_no_warn: assert property (fast_cond && !stall_cond |=> !overload_warning)
    else $error("warning raised by fast limit alone");
  chk_warn_cause: assert property (overload_warning |-> $past(stall_cond) && $past(run_ok) &&
    $past(phase_accel || phase_const || phase_decel))
    else $error("warning without stall");
  chk_stop_cause: assert property ($rose(stall_stop_fault) |->
    ($past(stall_cond) || $past(stall_cond, 2)) && !overload_warning)
    else $error("stop fault without stall or with warning");
  chk_trip_cause: assert property ($rose(stall_trip_fault) |-> $past(stall_cond) || $past(stall_cond, 2))
    else $error("trip fault without stall");
  chk_fault_halts: assert property (stall_stop_fault || stall_trip_fault |-> !run_ok)
    else $error("running while faulted");
  chk_halt_zero: assert property (!run_ok && $past(!run_ok) |-> out_freq == 16'h0000)
    else $error("output not zero while stopped");
  chk_out_ceiling: assert property (out_freq <= 16'h9C40)
    else $error("output above high speed limit");
  chk_fast_cause: assert property (fast_limit_active |-> $past(fast_cond))
    else $error("fast limit flag without cause");
  chk_read_idle: assert property (!rd_en |=> rd_data == 32'h00000000)
    else $error("read data outside read cycle");
endmodule

bind ofl_top ofl_chk chk_u (
  .sys_clk          (sys_clk),
  .rstn             (rstn),
  .rd_en            (rd_en),
  .rd_data          (rd_data),
  .stall_cond       (stall_cond),
  .fast_cond        (fast_cond),
  .phase_accel      (phase_accel),
  .phase_const      (phase_const),
  .phase_decel      (phase_decel),
  .out_freq         (out_freq),
  .overload_warning (overload_warning),
  .stall_stop_fault (stall_stop_fault),
  .stall_trip_fault (stall_trip_fault),
  .run_ok           (run_ok),
  .fast_limit_active(fast_limit_active)
);

/* File: ofl_partner.sv */
`timescale 1ns/100ps
// ************************************************************
// frequency command source
// ************************************************************
module ofl_partner (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire [15:0] target,
  input  wire        stall_active,
  output reg  [15:0] freq_cmd,
  output reg         freq_upd
);
  reg [1:0] tick_ff;
  // update every fourth cycle; lower the command while relief is requested
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tick_ff <= 2'h0;
      freq_cmd <= 16'h0000;
      freq_upd <= 1'b0;
    end else begin
      tick_ff <= tick_ff + 2'h1;
      freq_upd <= (tick_ff == 2'h3);
      if (stall_active)
        freq_cmd <= (freq_cmd > 16'h0064) ? freq_cmd - 16'h0064 : 16'h0000;
      else
        freq_cmd <= target;
    end
  end
endmodule

/* File: output_freq_limit_stall_select_tb_top.sv */
`timescale 1ns/100ps
`include "ofl_consts.vh"
module output_freq_limit_stall_select_tb_top;
  reg         sys_clk;
  reg         rstn;
  reg  [7:0]  addr;
  reg  [31:0] wr_data;
  reg         wr_en;
  reg         rd_en;
  reg  [15:0] target;
  reg  [2:0]  ph;
  reg         regen;
  reg         stall_cond;
  reg         fast_cond;
  wire [31:0] rd_data;
  wire [15:0] freq_cmd;
  wire        freq_upd;
  wire [15:0] out_freq;
  wire        warn;
  wire        stop;
  wire        trip;
  wire        run_ok;
  wire        stall_active;
  wire        fast_act;
  wire        irq;
  integer     errors;
  integer     compares;
  integer     i;

  ofl_top #(.TRIP_CYC(20)) dut_u (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .freq_cmd(freq_cmd), .freq_upd(freq_upd),
    .phase_accel(ph[0]), .phase_const(ph[1]), .phase_decel(ph[2]), .regen(regen),
    .stall_cond(stall_cond), .fast_cond(fast_cond), .out_freq(out_freq), .overload_warning(warn),
    .stall_stop_fault(stop), .stall_trip_fault(trip), .run_ok(run_ok), .stall_active(stall_active),
    .fast_limit_active(fast_act), .irq(irq));
  ofl_partner partner_u (.sys_clk(sys_clk), .rstn(rstn), .target(target), .stall_active(stall_active),
    .freq_cmd(freq_cmd), .freq_upd(freq_upd));

  // clock
  always #4 sys_clk = ~sys_clk;

  // ************************************************************
  // tasks
  // ************************************************************
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] exp);
    begin
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1 chk(rd_data, exp);
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #1;
    end
  endtask
  task drv(input [2:0] p, input rg, input st, input fc);
    begin
      @(posedge sys_clk);
      ph <= p;
      regen <= rg;
      stall_cond <= st;
      fast_cond <= fc;
    end
  endtask
  task tgt(input [15:0] v, input [15:0] exp);
    begin
      @(posedge sys_clk);
      target <= v;
      cyc(10);
      chk(out_freq, exp);
    end
  endtask
  task results;
    begin
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    addr = 8'h00;
    wr_data = 32'h00000000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    target = 16'h0000;
    ph = 3'h0;
    regen = 1'b0;
    stall_cond = 1'b0;
    fast_cond = 1'b0;
    errors = 0;
    compares = 0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    // reset values and an unmapped place
    rd(`OFL_REG_MAX, 32'h00002EE0);
    rd(`OFL_REG_HSMAX, 32'h00002EE0);
    rd(`OFL_REG_MIN, 32'h00000000);
    rd(`OFL_REG_STALL, 32'h00000000);
    rd(8'h20, 32'h00000000);
    // clamping and linked maxima
    wr(`OFL_REG_MIN, 32'h000003E8);
    tgt(16'h01F4, 16'h03E8);
    rd(`OFL_REG_STATUS, 32'h00000028);
    tgt(16'h4E20, 16'h2EE0);
    rd(`OFL_REG_STATUS, 32'h00000018);
    wr(`OFL_REG_HSMAX, 32'h00007530);
    rd(`OFL_REG_MAX, 32'h00007530);
    tgt(16'h4E20, 16'h4E20);
    wr(`OFL_REG_MAX, 32'h0000C350);
    rd(`OFL_REG_HSMAX, 32'h00002EE0);
    tgt(16'h4E20, 16'h2EE0);
    wr(`OFL_REG_HSMAX, 32'h00000064);
    rd(`OFL_REG_MAX, 32'h00002EE0);
    wr(`OFL_REG_MIN, 32'h00000000);
    tgt(16'h01F4, 16'h01F4);
    tgt(16'h2EE0, 16'h2EE0);
    // per phase disable of stall prevention
    for (i = 0; i < 3; i = i + 1) begin
      wr(`OFL_REG_STALL, 32'h1 << (i + 1));
      drv(3'h1 << i, 1'b0, 1'b1, 1'b0);
      cyc(4);
      chk(warn, 1'b0);
      drv(3'h1 << ((i + 1) % 3), 1'b0, 1'b1, 1'b0);
      cyc(3);
      chk(warn, 1'b1);
      chk(stall_active, 1'b1);
      drv(3'h0, 1'b0, 1'b0, 1'b0);
      cyc(4);
    end
    // fast current limit alone
    wr(`OFL_REG_STALL, 32'h00000000);
    drv(3'h1, 1'b0, 1'b0, 1'b1);
    cyc(3);
    chk(fast_act, 1'b1);
    chk(warn, 1'b0);
    wr(`OFL_REG_STALL, 32'h00000001);
    cyc(2);
    chk(fast_act, 1'b0);
    // driving and regenerating selections
    wr(`OFL_REG_STALL, `OFL_SEL_DRV_ALL);
    drv(3'h2, 1'b0, 1'b1, 1'b1);
    cyc(3);
    chk(warn, 1'b1);
    chk(fast_act, 1'b1);
    drv(3'h2, 1'b1, 1'b1, 1'b1);
    cyc(3);
    chk(warn, 1'b0);
    chk(fast_act, 1'b0);
    wr(`OFL_REG_STALL, `OFL_SEL_DRV_NOFR);
    drv(3'h2, 1'b0, 1'b1, 1'b1);
    cyc(3);
    chk(fast_act, 1'b0);
    chk(warn, 1'b1);
    wr(`OFL_REG_STALL, 32'h00000032);
    rd(`OFL_REG_STALL, 32'h00000065);
    drv(3'h0, 1'b0, 1'b0, 1'b0);
    cyc(4);
    // masked warning event, then unmask and clear
    wr(`OFL_REG_INT_STAT, 32'h00000007);
    wr(`OFL_REG_STALL, 32'h00000000);
    drv(3'h1, 1'b0, 1'b1, 1'b0);
    cyc(3);
    drv(3'h0, 1'b0, 1'b0, 1'b0);
    cyc(2);
    chk(irq, 1'b0);
    rd(`OFL_REG_INT_STAT, 32'h00000001);
    wr(`OFL_REG_INT_MASK, 32'h00000001);
    cyc(2);
    chk(irq, 1'b1);
    wr(`OFL_REG_INT_STAT, 32'h00000001);
    cyc(2);
    chk(irq, 1'b0);
    // stop on warning
    wr(`OFL_REG_INT_MASK, 32'h00000002);
    wr(`OFL_REG_STALL, 32'h00000010);
    drv(3'h1, 1'b0, 1'b1, 1'b0);
    cyc(4);
    chk(stop, 1'b1);
    chk(warn, 1'b0);
    chk(run_ok, 1'b0);
    chk(out_freq, 16'h0000);
    chk(irq, 1'b1);
    drv(3'h0, 1'b0, 1'b0, 1'b0);
    rd(`OFL_REG_INT_STAT, 32'h00000002);
    wr(`OFL_REG_CTRL, 32'h00000001);
    wr(`OFL_REG_INT_STAT, 32'h00000002);
    cyc(2);
    chk(stop, 1'b0);
    chk(run_ok, 1'b1);
    chk(irq, 1'b0);
    // stall held down to low frequency until trip
    wr(`OFL_REG_STALL, 32'h00000000);
    drv(3'h1, 1'b0, 1'b1, 1'b0);
    i = 0;
    while (trip !== 1'b1 && i < 1000) begin
      cyc(1);
      i = i + 1;
    end
    chk(trip, 1'b1);
    chk(i > 100, 1'b1);
    cyc(2);
    chk(out_freq, 16'h0000);
    rd(`OFL_REG_STATUS, 32'h00000004);
    rd(`OFL_REG_INT_STAT, 32'h00000005);
    drv(3'h0, 1'b0, 1'b0, 1'b0);
    results;
  end
endmodule
